// ---- aoc_angle_cfg.sv ----
// Operation
// - Upsampling uses a squared moving sum of length 2 or 4.
// - The interpolator takes the linearized angle of the chosen channel.
// - Bypass gives 2 us; else rate bit 0 gives 0.5 us and 1 gives 1 us.
// - Turns count freezes within 5.625 deg of each quadrant boundary.
// - The primary hysteresis-off bit removes that channel's dead zone.
// - The secondary hysteresis-off bit does the same for its channel.
// - Clamp codes 0..6 give 2/98 up to 8/92 percent; code 7 gives 2/98.
// - With report on, the done flag goes out once count-up completes.
// - No count-up takes place while the edge spacing field is zero.
// - Leaving an error starts a count-up unless fault reporting is off.
// - Primary entries 0..3 sit at bits 11:0 and 24:13 of two words.
// - Primary entries 8 and 9 sit at bits 10:0 and 21:11 with the clamp.
// - Secondary entries 0 and 1 share a word with its hysteresis-off bit.
// - All fields reset to zero and are readable and writable.
// - With fault reporting off, count-up still follows reset.
// - The channel select picks primary (0) or secondary (1) angle.
`timescale 1ns/1ps
module aoc_angle_cfg #(
    parameter int TC_W = 8
) (
    input  wire logic                 clk_i,          // 50 MHz clock
    input  wire logic                 resetn_i,       // sync reset, low
    input  wire logic                 ce_i,           // clock enable
    input  wire logic                 cfg_wr_i,       // register write
    input  wire logic                 cfg_rd_i,       // register read
    input  wire logic [7:0]           cfg_addr_i,     // word index
    input  wire logic [aoc_pkg::REG_W-1:0] cfg_wdata_i, // write data
    output logic      [aoc_pkg::REG_W-1:0] cfg_rdata_o, // read data
    output logic                      cfg_rvalid_o,   // read data strobe
    input  wire logic [aoc_pkg::ANG_W-1:0] primary_angle_i,   // lin out
    input  wire logic [aoc_pkg::ANG_W-1:0] secondary_angle_i, // lin out
    input  wire logic                 angle_valid_i,  // new angle pair
    input  wire logic                 incremental_output_channel_sel_i, // ch
    input  wire logic [5:0]           quad_edge_spacing_i, // slew field
    input  wire logic                 quad_error_i,   // output in error
    input  wire logic                 quad_countup_complete_i, // done
    output logic [aoc_pkg::ANG_W-1:0] interp_angle_o, // upsampled angle
    output logic                      interp_valid_o, // output strobe
    output logic [TC_W-1:0]           primary_turns_o,   // turns count
    output logic [TC_W-1:0]           secondary_turns_o, // turns count
    output logic [6:0]                pwm_clamp_low_o,   // low duty %
    output logic [6:0]                pwm_clamp_high_o,  // high duty %
    output logic                      quad_countup_start_o, // start pulse
    output logic                      quad_countup_busy_o,  // running
    output logic                      countup_done_flag_o,  // to pwm
    output logic [11:0]               primary_lin_entry_0_o,   // table
    output logic [11:0]               primary_lin_entry_1_o,   // table
    output logic [11:0]               primary_lin_entry_2_o,   // table
    output logic [11:0]               primary_lin_entry_3_o,   // table
    output logic [10:0]               primary_lin_entry_8_o,   // table
    output logic [10:0]               primary_lin_entry_9_o,   // table
    output logic [11:0]               secondary_lin_entry_0_o, // table
    output logic [11:0]               secondary_lin_entry_1_o, // table
    output logic [10:0]               secondary_lin_entry_22_o, // table
    output logic [10:0]               secondary_lin_entry_23_o  // table
);
    import aoc_pkg::*;

    localparam int SUB_W = $clog2(FAST_CYC);
    localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(FAST_CYC - 1);
    localparam logic [1:0] PH_LAST = 2'(PHASES - 1);
    localparam logic [1:0] PH_MID = 2'(MID_STEP - 1);

    typedef struct packed {
        logic [REG_W-1:0]        r26;
        logic [REG_W-1:0]        r27;
        logic [REG_W-1:0]        r2a;
        logic [REG_W-1:0]        r32;
        logic [REG_W-1:0]        r3d;
        logic [REG_W-1:0]        rdata;
        logic                    rvalid;
        logic [SUB_W-1:0]        sub;
        logic [1:0]              phase;
        logic                    samp;
        logic                    tick;
        logic [1:0][1:0]         quad;
        logic [1:0][TC_W-1:0]    turns;
        logic [6:0]              clamp_lo;
        logic [6:0]              clamp_hi;
        logic                    err_q;
        logic                    boot;
        aoc_cu_t                 cu;
        logic                    cu_start;
        logic                    cu_done;
        logic                    busy;
        logic                    done_flag;
    } aoc_st_t;

    aoc_st_t s_reg;
    aoc_st_t s_next;

    logic [1:0]            hyst_off;
    logic [1:0][1:0]       tc_quad_nx;
    logic [1:0][TC_W-1:0]  tc_turn_nx;
    logic [ANG_W-1:0]      interp_in;
    logic                  interp_bypass;
    logic                  interp_slow;
    logic [1:0]            fault_sel;

    // control fields steering the angle path and the count-up
    assign interp_bypass = s_reg.r26[INTERP_BYP_BIT];
    assign interp_slow   = s_reg.r26[INTERP_RATE_BIT];
    assign hyst_off[0]   = s_reg.r27[HYST_OFF_BIT];
    assign hyst_off[1]   = s_reg.r32[HYST_OFF_BIT];
    assign fault_sel     = s_reg.r3d[FAULT_LSB +: FAULT_W];

    // selected channel feeds the interpolator
    assign interp_in = incremental_output_channel_sel_i ?
                       secondary_angle_i : primary_angle_i;

    // per channel turns count with a dead zone at each quadrant edge
    for (genvar c = 0; c < 2; c++) begin : g_tc
        logic [ANG_W-1:0] ang;
        logic [1:0]       q;
        logic             frozen;
        assign ang = (c == 0) ? primary_angle_i : secondary_angle_i;
        assign q   = ang[ANG_W-1 -: 2];
        assign frozen = ~hyst_off[c] &
                        ((ang[13:0] < HYST_HALF) ||
                         (ang[13:0] >= HYST_TOP));
        always_comb begin
            tc_quad_nx[c] = s_reg.quad[c];
            tc_turn_nx[c] = s_reg.turns[c];
            if (angle_valid_i && !frozen) begin
                tc_quad_nx[c] = q;
                if (q == s_reg.quad[c] + 2'h1) begin
                    tc_turn_nx[c] = s_reg.turns[c] + TC_W'(1);
                end else if (q == s_reg.quad[c] - 2'h1) begin
                    tc_turn_nx[c] = s_reg.turns[c] - TC_W'(1);
                end
            end
        end
    end

    // next-state logic for registers, timing, count-up
    always_comb begin
        logic       err_exit;
        logic       boot_go;
        logic       trig;
        logic [2:0] code;
        err_exit = 1'b0;
        boot_go = 1'b0;
        trig = 1'b0;
        code = '0;
        s_next = s_reg;
        s_next.rvalid = 1'b0;
        s_next.samp = 1'b0;
        s_next.tick = 1'b0;
        s_next.cu_start = 1'b0;

        // register writes, full word
        if (cfg_wr_i) begin
            unique case (cfg_addr_i)
                ADDR_INTERP: s_next.r26 = cfg_wdata_i;
                ADDR_PLIN_B: s_next.r27 = cfg_wdata_i;
                ADDR_CLAMP:  s_next.r2a = cfg_wdata_i;
                ADDR_SLIN_A: s_next.r32 = cfg_wdata_i;
                ADDR_CUP:    s_next.r3d = cfg_wdata_i;
                default: ;
            endcase
        end

        // register reads, unmapped index reads zero
        if (cfg_rd_i) begin
            s_next.rvalid = 1'b1;
            unique case (cfg_addr_i)
                ADDR_INTERP: s_next.rdata = s_reg.r26;
                ADDR_PLIN_B: s_next.rdata = s_reg.r27;
                ADDR_CLAMP:  s_next.rdata = s_reg.r2a;
                ADDR_SLIN_A: s_next.rdata = s_reg.r32;
                ADDR_CUP:    s_next.rdata = s_reg.r3d;
                default:     s_next.rdata = '0;
            endcase
        end

        // 0.5 us base ticks, four phases make the 2 us input period
        s_next.sub = s_reg.sub + SUB_W'(1);
        if (s_reg.sub == SUB_LAST) begin
            s_next.sub = '0;
            s_next.phase = s_reg.phase + 2'h1;
            s_next.samp = (s_reg.phase == PH_LAST);
            if (interp_bypass) begin
                s_next.tick = (s_reg.phase == PH_LAST);
            end else if (interp_slow) begin
                s_next.tick = (s_reg.phase[0] == PH_MID[0]);
            end else begin
                s_next.tick = 1'b1;
            end
        end

        // turns counts
        s_next.quad = tc_quad_nx;
        s_next.turns = tc_turn_nx;

        // duty clamp decode, code 7 folds back to the first pair
        code = s_reg.r2a[CLAMP_LSB +: CLAMP_W];
        if (code == CLAMP_WRAP) begin
            code = '0;
        end
        s_next.clamp_lo = CLAMP_LO_BASE + {4'h0, code};
        s_next.clamp_hi = CLAMP_HI_BASE - {4'h0, code};

        // count-up triggers after reset and on leaving an error
        s_next.err_q = quad_error_i;
        s_next.boot = 1'b0;
        err_exit = s_reg.err_q & ~quad_error_i &
                   (fault_sel != FAULT_RPT_OFF);
        boot_go = s_reg.boot &
                  (~s_reg.r3d[SR_DLY_BIT] |
                   (fault_sel == FAULT_RPT_OFF));
        trig = (err_exit | boot_go) &
               (quad_edge_spacing_i != 6'h00);

        unique case (s_reg.cu)
            CU_IDLE: begin
                if (trig && !quad_error_i) begin
                    s_next.cu = CU_RUN;
                    s_next.cu_start = 1'b1;
                    s_next.cu_done = 1'b0;
                end
            end
            CU_RUN: begin
                if (quad_error_i) begin
                    s_next.cu = CU_IDLE; // abandoned, error takes over
                end else if (quad_countup_complete_i) begin
                    s_next.cu = CU_IDLE;
                    s_next.cu_done = 1'b1;
                end
            end
        endcase
        if (quad_error_i) begin
            s_next.cu_done = 1'b0;
        end
        // busy kept in a flop so the port is a register output
        s_next.busy = (s_next.cu == CU_RUN);

        // done flag reaches pwm only when reporting is enabled
        s_next.done_flag = s_next.cu_done &
                           s_next.r3d[CUP_RPT_BIT];
    end

    // state register; report bit resets to zero as advised
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            s_reg <= '0;
            s_reg.boot <= 1'b1;
        end else if (ce_i) begin
            s_reg <= s_next;
        end
    end

    // interpolator on the selected angle
    aoc_interp #(
        .ANG_W    (ANG_W)
    ) u_interp (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .ce_i     (ce_i),
        .sample_i (s_reg.samp),
        .tick_i   (s_reg.tick),
        .bypass_i (interp_bypass),
        .r4_i     (~interp_slow),
        .angle_i  (interp_in),
        .angle_o  (interp_angle_o),
        .valid_o  (interp_valid_o)
    );

    // register-backed outputs
    assign cfg_rdata_o          = s_reg.rdata;
    assign cfg_rvalid_o         = s_reg.rvalid;
    assign primary_turns_o      = s_reg.turns[0];
    assign secondary_turns_o    = s_reg.turns[1];
    assign pwm_clamp_low_o      = s_reg.clamp_lo;
    assign pwm_clamp_high_o     = s_reg.clamp_hi;
    assign quad_countup_start_o = s_reg.cu_start;
    assign quad_countup_busy_o  = s_reg.busy;
    assign countup_done_flag_o  = s_reg.done_flag;

    // linearization table fields
    assign primary_lin_entry_0_o =
        s_reg.r26[LIN12_LO_LSB +: LIN12_W];
    assign primary_lin_entry_1_o =
        s_reg.r26[LIN12_HI_LSB +: LIN12_W];
    assign primary_lin_entry_2_o =
        s_reg.r27[LIN12_LO_LSB +: LIN12_W];
    assign primary_lin_entry_3_o =
        s_reg.r27[LIN12_HI_LSB +: LIN12_W];
    assign primary_lin_entry_8_o =
        s_reg.r2a[LIN11_LO_LSB +: LIN11_W];
    // entry 9 is kept with the primary table; its channel is ambiguous
    assign primary_lin_entry_9_o =
        s_reg.r2a[LIN11_HI_LSB +: LIN11_W];
    assign secondary_lin_entry_0_o =
        s_reg.r32[LIN12_LO_LSB +: LIN12_W];
    assign secondary_lin_entry_1_o =
        s_reg.r32[LIN12_HI_LSB +: LIN12_W];
    assign secondary_lin_entry_22_o =
        s_reg.r3d[LIN11_LO_LSB +: LIN11_W];
    assign secondary_lin_entry_23_o =
        s_reg.r3d[LIN11_HI_LSB +: LIN11_W];
endmodule // aoc_angle_cfg

// ---- aoc_angle_cfg_sva.sv ----
`timescale 1ns/1ps
module aoc_angle_cfg_sva (
    input wire logic                        clk_i,          // clock
    input wire logic                        resetn_i,       // sync reset
    input wire logic                        ce_i,           // enable
    input wire logic                        cfg_wr_i,       // write
    input wire logic                        cfg_rd_i,       // read
    input wire logic [7:0]                  cfg_addr_i,     // index
    input wire logic [aoc_pkg::REG_W-1:0]   cfg_wdata_i,    // wdata
    input wire logic                        cfg_rvalid_o,   // rvalid
    input wire logic [5:0]                  quad_edge_spacing_i, // slew
    input wire logic                        quad_error_i,   // error
    input wire logic                        quad_countup_complete_i, // done
    input wire logic                        interp_valid_o, // strobe
    input wire logic [6:0]                  pwm_clamp_low_o,  // low %
    input wire logic [6:0]                  pwm_clamp_high_o, // high %
    input wire logic                        quad_countup_start_o, // start
    input wire logic                        quad_countup_busy_o,  // busy
    input wire logic                        countup_done_flag_o   // flag
);
    import aoc_pkg::*;
    logic       rpt_q;
    logic [1:0] fsel_q;

    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    // shadow of report bit and fault code
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rpt_q <= 1'b0;
            fsel_q <= 2'h0;
        end else if (ce_i && cfg_wr_i && cfg_addr_i == ADDR_CUP) begin
            rpt_q <= cfg_wdata_i[CUP_RPT_BIT];
            fsel_q <= cfg_wdata_i[FAULT_LSB +: FAULT_W];
        end
    end

    // register port answers
    a_rvalid_after_read: assert property (
        ce_i && cfg_rd_i |=> cfg_rvalid_o)
        else $error("read strobe without rvalid");
    a_rvalid_only_read: assert property (
        !(ce_i && cfg_rd_i) |=> !cfg_rvalid_o)
        else $error("rvalid without read");
    // duty clamps
    a_clamp_pair_sum: assert property (
        pwm_clamp_low_o != 7'h00 |->
        8'(pwm_clamp_low_o) + 8'(pwm_clamp_high_o) == 8'd100)
        else $error("clamp pair not summing to 100");
    a_clamp_low_range: assert property (
        pwm_clamp_low_o != 7'h00 |->
        pwm_clamp_low_o inside {[7'h02:7'h08]})
        else $error("low clamp out of range");
    // count-up sequencing
    a_done_needs_report: assert property (
        countup_done_flag_o |-> rpt_q || $past(rpt_q))
        else $error("done flag with report off");
    a_start_one_pulse: assert property (
        quad_countup_start_o |=> !quad_countup_start_o)
        else $error("start longer than one cycle");
    a_start_sets_busy: assert property (
        quad_countup_start_o |-> quad_countup_busy_o)
        else $error("start without busy");
    a_start_needs_spacing: assert property (
        quad_countup_start_o |-> $past(quad_edge_spacing_i) != 6'h00)
        else $error("count-up with zero spacing");
    a_err_fall_starts: assert property (
        ce_i && $fell(quad_error_i) && !quad_countup_busy_o
        && fsel_q != FAULT_RPT_OFF && quad_edge_spacing_i != 6'h00
        |=> quad_countup_start_o)
        else $error("no count-up after error");
    a_fault_off_quiet: assert property (
        ce_i && $fell(quad_error_i) && !quad_countup_busy_o
        && fsel_q == FAULT_RPT_OFF |=> !quad_countup_start_o)
        else $error("count-up with reporting off");
    a_complete_ends_busy: assert property (
        ce_i && quad_countup_busy_o && quad_countup_complete_i
        |=> !quad_countup_busy_o)
        else $error("busy kept after complete");
    a_interp_strobe_gap: assert property (
        interp_valid_o |=> !interp_valid_o [*8])
        else $error("interpolator strobes too close");

    // main scenarios
    c_start: cover property (quad_countup_start_o);
    c_flag: cover property (countup_done_flag_o);
    c_strobe: cover property (interp_valid_o ##1 !interp_valid_o);
endmodule // aoc_angle_cfg_sva

bind aoc_angle_cfg aoc_angle_cfg_sva u_sva (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .cfg_wr_i(cfg_wr_i),
    .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i), .cfg_wdata_i(cfg_wdata_i),
    .cfg_rvalid_o(cfg_rvalid_o), .quad_edge_spacing_i(quad_edge_spacing_i),
    .quad_error_i(quad_error_i),
    .quad_countup_complete_i(quad_countup_complete_i),
    .interp_valid_o(interp_valid_o), .pwm_clamp_low_o(pwm_clamp_low_o),
    .pwm_clamp_high_o(pwm_clamp_high_o),
    .quad_countup_start_o(quad_countup_start_o),
    .quad_countup_busy_o(quad_countup_busy_o),
    .countup_done_flag_o(countup_done_flag_o));

// ---- aoc_angle_cfg_tb.sv ----
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
    mismatches++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module aoc_angle_cfg_tb;
    import aoc_pkg::*;
    logic             clk_i, resetn_i, ce_i, wr, rd, rv, avld, sel;
    logic             err, cdone, ivld, cstart, cbusy, dflag;
    logic [7:0]       addr, pt, st;
    logic [REG_W-1:0] wd, rdat;
    logic [ANG_W-1:0] pang, sang, iang;
    logic [5:0]       spc;
    logic [6:0]       clo, chi;
    logic [11:0]      pe0, pe1, pe2, pe3, se0, se1;
    logic [10:0]      pe8, pe9, se22, se23;
    int               mismatches, checked;
    localparam logic [REG_W-1:0] PAT = 26'h2b4d1e7;

    aoc_angle_cfg dut (.clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i),
        .cfg_wr_i(wr), .cfg_rd_i(rd), .cfg_addr_i(addr), .cfg_wdata_i(wd),
        .cfg_rdata_o(rdat), .cfg_rvalid_o(rv), .primary_angle_i(pang),
        .secondary_angle_i(sang), .angle_valid_i(avld),
        .incremental_output_channel_sel_i(sel), .quad_edge_spacing_i(spc),
        .quad_error_i(err), .quad_countup_complete_i(cdone),
        .interp_angle_o(iang), .interp_valid_o(ivld),
        .primary_turns_o(pt), .secondary_turns_o(st),
        .pwm_clamp_low_o(clo), .pwm_clamp_high_o(chi),
        .quad_countup_start_o(cstart), .quad_countup_busy_o(cbusy),
        .countup_done_flag_o(dflag), .primary_lin_entry_0_o(pe0),
        .primary_lin_entry_1_o(pe1), .primary_lin_entry_2_o(pe2),
        .primary_lin_entry_3_o(pe3), .primary_lin_entry_8_o(pe8),
        .primary_lin_entry_9_o(pe9), .secondary_lin_entry_0_o(se0),
        .secondary_lin_entry_1_o(se1), .secondary_lin_entry_22_o(se22),
        .secondary_lin_entry_23_o(se23));

    // 50 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask

    task automatic cw(input logic [7:0] a, input logic [REG_W-1:0] d);
        wr = 1'b1;
        addr = a;
        wd = d;
        step(1);
        wr = 1'b0;
        step(1);
    endtask

    task automatic cr(input logic [7:0] a, output logic [REG_W-1:0] d);
        rd = 1'b1;
        addr = a;
        step(1);
        rd = 1'b0;
        `CHK(rv, 1'b1)
        d = rdat;
        step(1);
    endtask

    task automatic errp;
        err = 1'b1;
        step(3);
        `CHK(cbusy, 1'b0)
        err = 1'b0;
        step(2);
    endtask

    task automatic gap(output int n);
        int i;
        i = 0;
        n = 1;
        while (ivld !== 1'b1 && i < 300) begin
            step(1);
            i++;
        end
        step(1);
        while (ivld !== 1'b1 && n < 300) begin
            step(1);
            n++;
        end
    endtask

    task automatic setang(input logic [ANG_W-1:0] a);
        pang = a;
        sang = a;
        step(3);
    endtask

    task automatic t_regs;
        logic [7:0]       am [5];
        logic [REG_W-1:0] w [5];
        logic [REG_W-1:0] d;
        am = '{ADDR_INTERP, ADDR_PLIN_B, ADDR_CLAMP, ADDR_SLIN_A, ADDR_CUP};
        for (int i = 0; i < 5; i++) begin
            w[i] = PAT ^ REG_W'(i * 7);
            cr(am[i], d);
            `CHK(d, REG_RST)
            cw(am[i], w[i]);
            cr(am[i], d);
            `CHK(d, w[i])
        end
        `CHK({pe1, pe0}, {w[0][24:13], w[0][11:0]})
        `CHK({pe3, pe2}, {w[1][24:13], w[1][11:0]})
        `CHK({pe9, pe8}, {w[2][21:11], w[2][10:0]})
        `CHK({se1, se0}, {w[3][24:13], w[3][11:0]})
        `CHK({se23, se22}, {w[4][21:11], w[4][10:0]})
        cw(8'h28, PAT);
        cr(8'h28, d);
        `CHK(d, REG_RST)
        for (int i = 0; i < 5; i++) cw(am[i], REG_RST);
    endtask

    task automatic t_clamp;
        logic [6:0] lo;
        for (int c = 0; c < 8; c++) begin
            cw(ADDR_CLAMP, REG_W'(c) << CLAMP_LSB);
            step(1);
            lo = (c == 7) ? 7'h02 : 7'(2 + c);
            `CHK({clo, chi}, {lo, 7'd100 - lo})
        end
    endtask

    task automatic t_rate;
        logic [REG_W-1:0] cf [4];
        int               ex [4];
        int               n;
        cf = '{26'h0000000, 26'h2000000, 26'h0001000, 26'h2001000};
        ex = '{25, 50, 100, 100};
        for (int i = 0; i < 4; i++) begin
            cw(ADDR_INTERP, cf[i]);
            gap(n);
            gap(n);
            `CHK(n, ex[i])
        end
        cw(ADDR_INTERP, REG_RST);
        pang = 16'h1234;
        sang = 16'h5678;
        step(400);
        `CHK(iang, 16'h1234)
        sel = 1'b1;
        step(400);
        `CHK(iang, 16'h5678)
    endtask

    task automatic t_turns;
        logic [7:0] p0, s0;
        avld = 1'b1;
        setang(16'h2000);
        p0 = pt;
        s0 = st;
        cw(ADDR_PLIN_B, 26'h0001000);
        setang(16'h4200);
        `CHK({pt, st}, {p0 + 8'h01, s0})
        setang(16'h4600);
        `CHK({pt, st}, {p0 + 8'h01, s0 + 8'h01})
        cw(ADDR_PLIN_B, REG_RST);
        cw(ADDR_SLIN_A, 26'h0001000);
        setang(16'h3e00);
        `CHK({pt, st}, {p0 + 8'h01, s0})
        setang(16'h3000);
        `CHK({pt, st}, {p0, s0})
        avld = 1'b0;
        cw(ADDR_SLIN_A, REG_RST);
    endtask

    task automatic t_cup;
        cw(ADDR_CUP, 26'h2000000);
        errp;
        `CHK(cbusy, 1'b1)
        cdone = 1'b1;
        step(1);
        cdone = 1'b0;
        step(2);
        `CHK({cbusy, dflag}, 2'b01)
        cw(ADDR_CUP, REG_RST);
        `CHK(dflag, 1'b0)
        cw(ADDR_CUP, 26'h0800000);
        errp;
        `CHK(cbusy, 1'b0)
        cw(ADDR_CUP, REG_RST);
        spc = 6'h00;
        errp;
        `CHK(cbusy, 1'b0)
        spc = 6'h3f;
        errp;
        `CHK(cbusy, 1'b1)
        // low enable holds count-up, away from a strobe
        while (ivld !== 1'b1) step(1);
        step(1);
        {ce_i, cdone} = 2'b01;
        step(3);
        `CHK(cbusy, 1'b1)
        ce_i = 1'b1;
        step(1);
        cdone = 1'b0;
        `CHK(cbusy, 1'b0)
    endtask

    // count-up armed by reset runs to completion, flag stays off
    task automatic t_boot;
        step(1);
        `CHK(cstart, 1'b1)
        step(1);
        `CHK(cbusy, 1'b1)
        cdone = 1'b1;
        step(1);
        cdone = 1'b0;
        step(2);
        `CHK({cbusy, dflag}, 2'b00)
    endtask

    task automatic print_verdict;
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // main sequence
    initial begin
        {resetn_i, wr, rd, addr, wd, pang, sang, avld, sel, err, cdone} = '0;
        ce_i = 1'b1;
        spc = 6'h05;
        mismatches = 0;
        checked = 0;
        step(16);
        resetn_i = 1'b1;
        t_boot;
        t_regs;
        t_clamp;
        t_rate;
        t_turns;
        t_cup;
        print_verdict;
    end

    // watchdog, more than ten times the expected run
    initial begin
        #400000;
        mismatches++;
        print_verdict;
    end
endmodule // aoc_angle_cfg_tb

// ---- aoc_interp.sv ----
`timescale 1ns/1ps
module aoc_interp #(
    parameter int ANG_W = 16
) (
    input  wire logic             clk_i,    // system clock
    input  wire logic             resetn_i, // sync reset, active low
    input  wire logic             ce_i,     // clock enable
    input  wire logic             sample_i, // new input angle
    input  wire logic             tick_i,   // output instant
    input  wire logic             bypass_i, // pass held angle through
    input  wire logic             r4_i,     // moving sum length 4, else 2
    input  wire logic [ANG_W-1:0] angle_i,  // selected channel angle
    output logic      [ANG_W-1:0] angle_o,  // upsampled angle
    output logic                  valid_o   // one-cycle output strobe
);
    typedef struct packed {
        logic [ANG_W-1:0]      held;
        logic [3:0][ANG_W-1:0] hist;
        logic [ANG_W-1:0]      out;
        logic                  vld;
    } aoc_ip_st_t;

    aoc_ip_st_t s_reg;
    aoc_ip_st_t s_next;

    // zero-stuffed input through two moving sums of length r, scaled by r:
    // first sum acts as a hold, second averages the last r held values
    always_comb begin
        logic [ANG_W-1:0]        cur;
        logic [ANG_W-1:0]        d;
        logic signed [ANG_W+1:0] sum;
        logic signed [ANG_W+1:0] sh;
        cur = sample_i ? angle_i : s_reg.held;
        d = '0;
        sum = '0;
        sh = '0;
        s_next = s_reg;
        s_next.vld = 1'b0;
        s_next.held = cur;
        if (tick_i) begin
            s_next.hist = {s_reg.hist[2:0], cur};
            // wrap-safe sum of offsets from the newest value
            for (int k = 0; k < 3; k++) begin
                if (k < 1 || r4_i) begin
                    d = s_reg.hist[k] - cur;
                    sum = sum + {{2{d[ANG_W-1]}}, d};
                end
            end
            sh = r4_i ? (sum >>> 2) : (sum >>> 1);
            s_next.out = bypass_i ? cur : cur + sh[ANG_W-1:0];
            s_next.vld = 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            s_reg <= '0;
        end else if (ce_i) begin
            s_reg <= s_next;
        end
    end

    assign angle_o = s_reg.out;
    assign valid_o = s_reg.vld;
endmodule // aoc_interp

// ---- aoc_pkg.sv ----
package aoc_pkg;
    // register word indices
    localparam logic [7:0] ADDR_INTERP = 8'h26;
    localparam logic [7:0] ADDR_PLIN_B = 8'h27;
    localparam logic [7:0] ADDR_CLAMP  = 8'h2a;
    localparam logic [7:0] ADDR_SLIN_A = 8'h32;
    localparam logic [7:0] ADDR_CUP    = 8'h3d;
    localparam int         REG_W       = 26;
    localparam logic [25:0] REG_RST    = 26'h0000000;

    // field positions
    localparam int INTERP_RATE_BIT = 25;
    localparam int INTERP_BYP_BIT  = 12;
    localparam int HYST_OFF_BIT    = 12;
    localparam int CLAMP_LSB       = 23;
    localparam int CLAMP_W         = 3;
    localparam int CUP_RPT_BIT     = 25;
    localparam int SR_DLY_BIT      = 24;
    localparam int FAULT_LSB       = 22;
    localparam int FAULT_W         = 2;
    localparam int LIN12_LO_LSB    = 0;
    localparam int LIN12_HI_LSB    = 13;
    localparam int LIN12_W         = 12;
    localparam int LIN11_LO_LSB    = 0;
    localparam int LIN11_HI_LSB    = 11;
    localparam int LIN11_W         = 11;

    // timing of the interpolated angle output
    localparam int CLK_NS      = 20;
    localparam int RATE_HI_NS  = 500;
    localparam int RATE_MID_NS = 1000;
    localparam int RATE_BYP_NS = 2000;
    localparam int FAST_CYC    = RATE_HI_NS / CLK_NS;
    localparam int PHASES      = RATE_BYP_NS / RATE_HI_NS;
    localparam int MID_STEP    = RATE_MID_NS / RATE_HI_NS;

    // turns count hysteresis, 5.625 deg either side of a quadrant edge
    localparam int         ANG_W      = 16;
    localparam logic [13:0] HYST_HALF = 14'h0400;
    localparam logic [13:0] HYST_TOP  = 14'h3c00;

    // pwm duty clamps in percent
    localparam logic [6:0] CLAMP_LO_BASE = 7'h02;
    localparam logic [6:0] CLAMP_HI_BASE = 7'h62;
    localparam logic [2:0] CLAMP_WRAP    = 3'h7;

    // fault report code that turns quadrature diagnostics off
    localparam logic [1:0] FAULT_RPT_OFF = 2'h2;

    typedef enum logic [0:0] {CU_IDLE, CU_RUN} aoc_cu_t;
endpackage
